// >>> count_store.sv
// Holds the last latched count of each axis; registered read port.
// Assumes each axis writes only its own word.
`timescale 1ns/100ps
`default_nettype none
module count_store #(
	parameter int WIDTH = 24,
	parameter int WORDS = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Write side, one port per word
	input wire logic [WORDS-1:0] wr_en,
	input wire logic [WORDS*WIDTH-1:0] wr_data,
	// Read side
	input wire logic [$clog2(WORDS)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data_r
);
	logic [WIDTH-1:0] mem_r [WORDS];
	logic [WIDTH-1:0] mem_nxt [WORDS];
	logic [WIDTH-1:0] rd_data_nxt;

	// Address port needs at least one bit
	if (WORDS < 2 || WIDTH < 1) begin : g_bad_params
		$error("count store: unsupported parameters");
	end

	always_comb begin
		for (int i = 0; i < WORDS; i++) begin
			mem_nxt[i] = wr_en[i] ? wr_data[i*WIDTH +: WIDTH] : mem_r[i];
		end
		rd_data_nxt = mem_r[rd_addr];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_r[i] <= '0;
			end
			rd_data_r <= '0;
		end else if (ce) begin
			mem_r <= mem_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end
endmodule // count_store
`default_nettype wire

// >>> magnetostrictive_position_readout.sv
// Two-axis magnetostrictive transducer readout: interrogate, count, latch.
// Assumes return lines and the 60 MHz reference are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module magnetostrictive_position_readout
	import position_readout_pkg::*;
#(
	parameter int REFRESH = position_readout_pkg::REFRESH_CYCLES,
	parameter int TIMEOUT = position_readout_pkg::TIMEOUT_CYCLES,
	parameter int WIDTH = position_readout_pkg::COUNT_W
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Axis configuration and reference
	input wire logic [position_readout_pkg::AXES-1:0] pwm_mode,
	input wire logic ref_60mhz,
	// Transducer pins
	output logic [position_readout_pkg::AXES-1:0] interrogate_r,
	input wire logic [position_readout_pkg::AXES-1:0] return_in,
	// Results
	output position_readout_pkg::axis_result_type [position_readout_pkg::AXES-1:0] result_r,
	output logic [position_readout_pkg::AXES-1:0] sample_done_r,
	// Count readback
	input wire logic rd_axis,
	output logic [WIDTH-1:0] rd_count_r
);
	import position_readout_pkg::*;

	// Refuse settings the fixed result layout or the refresh timing cannot hold
	if (WIDTH != COUNT_W || REFRESH <= TIMEOUT + INTERROGATE_CYCLES + 2 ||
	    TIMEOUT < 1 || AXES != 2) begin : g_bad_params
		$error("position readout: unsupported parameters");
	end

	// Shared refresh timer and reference edge detection
	logic [31:0] tick_cnt_r, tick_cnt_nxt;
	logic tick_r, tick_nxt;
	logic ref_prev_r, ref_prev_nxt;
	logic ref_edge;

	assign ref_edge = ref_60mhz ^ ref_prev_r;

	always_comb begin
		ref_prev_nxt = ref_60mhz;
		tick_nxt = 1'b0;
		if (tick_cnt_r == 32'(REFRESH - 1)) begin
			tick_cnt_nxt = '0;
			tick_nxt = 1'b1;
		end else begin
			tick_cnt_nxt = tick_cnt_r + 32'h00000001;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
			ref_prev_r <= 1'b0;
		end else if (ce) begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
			ref_prev_r <= ref_prev_nxt;
		end
	end

	logic [AXES-1:0] latch_en;
	logic [AXES*WIDTH-1:0] latch_data;

	genvar a;
	generate
		for (a = 0; a < AXES; a++) begin : g_axis
			axis_state_type st_r, st_nxt;
			logic [WIDTH-1:0] cnt_r, cnt_nxt;
			logic [31:0] tmr_r, tmr_nxt;
			logic ret_prev_r, ret_prev_nxt;
			logic int_nxt;
			logic noise_acc_r, noise_acc_nxt;
			logic done_seen_r, done_seen_nxt;
			logic done_nxt;
			axis_result_type res_nxt;
			logic rise;
			logic mode_pwm;
			logic noise_evt;
			logic ovf_evt;

			assign rise = return_in[a] & ~ret_prev_r;
			assign mode_pwm = pwm_mode[a];

			always_comb begin
				st_nxt = st_r;
				cnt_nxt = cnt_r;
				tmr_nxt = tmr_r;
				ret_prev_nxt = return_in[a];
				int_nxt = 1'b0;
				noise_acc_nxt = noise_acc_r;
				done_seen_nxt = done_seen_r;
				done_nxt = 1'b0;
				res_nxt = result_r[a];
				noise_evt = 1'b0;
				ovf_evt = 1'b0;
				case (st_r)
					ST_IDLE: begin
						// Return activity outside a measurement is noise
						if (mode_pwm ? return_in[a] : rise) begin
							noise_evt = 1'b1;
							noise_acc_nxt = 1'b1;
						end
					end
					ST_PULSE: begin
						int_nxt = 1'b1;
						if (tmr_r == 32'(INTERROGATE_CYCLES - 1)) begin
							st_nxt = ST_WAIT;
							tmr_nxt = '0;
							int_nxt = 1'b0;
						end else begin
							tmr_nxt = tmr_r + 32'h00000001;
						end
					end
					ST_WAIT, ST_COUNT: begin
						tmr_nxt = tmr_r + 32'h00000001;
						if (st_r == ST_COUNT && ref_edge) begin
							if (&cnt_r) begin
								ovf_evt = 1'b1;
								res_nxt.overflow = 1'b1;
							end else begin
								cnt_nxt = cnt_r + 1'b1;
							end
						end
						if (st_r == ST_WAIT && (mode_pwm ? return_in[a] : rise)) begin
							st_nxt = ST_COUNT;
						end else if (st_r == ST_COUNT &&
						             (mode_pwm ? !return_in[a] : rise)) begin
							st_nxt = ST_DONE;
						end else if (tmr_r == 32'(TIMEOUT - 1)) begin
							st_nxt = ST_IDLE;
						end
					end
					ST_DONE: begin
						res_nxt.count = cnt_r;
						res_nxt.valid = 1'b1;
						done_nxt = 1'b1;
						done_seen_nxt = 1'b1;
						st_nxt = ST_IDLE;
					end
					default: st_nxt = ST_IDLE;
				endcase
				// New measurement: publish faults, clear counter, interrogate
				if (tick_r) begin
					// Events in the tick cycle still count: set wins
					res_nxt.no_transducer = ~(done_seen_r | done_nxt);
					res_nxt.noise = noise_acc_r | noise_evt;
					if ((done_seen_r | done_nxt) && !ovf_evt) begin
						res_nxt.overflow = 1'b0;
					end
					noise_acc_nxt = 1'b0;
					done_seen_nxt = 1'b0;
					cnt_nxt = COUNT_RESET;
					tmr_nxt = '0;
					st_nxt = ST_PULSE;
					int_nxt = 1'b1;
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					st_r <= ST_IDLE;
					cnt_r <= COUNT_RESET;
					tmr_r <= '0;
					ret_prev_r <= 1'b0;
					interrogate_r[a] <= 1'b0;
					noise_acc_r <= 1'b0;
					done_seen_r <= 1'b1;
					sample_done_r[a] <= 1'b0;
					result_r[a] <= '0;
				end else if (ce) begin
					st_r <= st_nxt;
					cnt_r <= cnt_nxt;
					tmr_r <= tmr_nxt;
					ret_prev_r <= ret_prev_nxt;
					interrogate_r[a] <= int_nxt;
					noise_acc_r <= noise_acc_nxt;
					done_seen_r <= done_seen_nxt;
					sample_done_r[a] <= done_nxt;
					result_r[a] <= res_nxt;
				end
			end

			assign latch_en[a] = done_nxt;
			assign latch_data[a*WIDTH +: WIDTH] = cnt_r;
		end
	endgenerate

	count_store #(
		.WIDTH(WIDTH),
		.WORDS(AXES)
	) u_store (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.wr_en(latch_en),
		.wr_data(latch_data),
		.rd_addr(rd_axis),
		.rd_data_r(rd_count_r)
	);
endmodule // magnetostrictive_position_readout
`default_nettype wire

// >>> magnetostrictive_position_readout_tb.sv
// Self-checking bench for the two-axis readout.
// Assumes a shortened refresh of 2000 cycles.
`timescale 1ns/100ps
`default_nettype none
module magnetostrictive_position_readout_tb;
	import position_readout_pkg::*;
	logic clk, reset_n, ref_60mhz, rd_axis;
	logic [1:0] pwm_mode, interrogate_r, return_in, sample_done_r, mute;
	logic [1:0] extra;
	axis_result_type [1:0] result_r;
	logic [23:0] rd_count_r;
	logic [7:0] width [2];
	logic [23:0] q0 [$];
	logic [23:0] q1 [$];
	logic [31:0] seed;
	int n_mismatch, tests_run;
	magnetostrictive_position_readout #(.REFRESH(2000), .TIMEOUT(1500)) DUT (
		.clk(clk), .reset_n(reset_n), .ce(1'b1), .pwm_mode(pwm_mode),
		.ref_60mhz(ref_60mhz), .interrogate_r(interrogate_r),
		.return_in(return_in), .result_r(result_r),
		.sample_done_r(sample_done_r), .rd_axis(rd_axis),
		.rd_count_r(rd_count_r));
	for (genvar a = 0; a < 2; a++) begin : g_ax
		transducer_model M (.clk(clk), .interrogate(interrogate_r[a]),
			.ret(return_in[a]), .pwm(pwm_mode[a]), .mute(mute[a]),
			.width(width[a]), .extra(extra[a]));
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk_count(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		// Sampling phase allows two counts either way
		if ((got - exp + 24'h000002 <= 24'h000004) !== 1'b1) begin
			n_mismatch++;
			$display("Error %0t count %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t flags %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) ref_60mhz <= ~ref_60mhz;
	always @(negedge clk) begin
		if (sample_done_r[0] === 1'b1 && q0.size() > 0) begin
			chk_count(result_r[0].count, q0.pop_front());
			chk_flag(result_r[0][3:0], 4'h8);
		end
		if (sample_done_r[1] === 1'b1 && q1.size() > 0)
			chk_count(result_r[1].count, q1.pop_front());
	end
	// Twenty refresh periods of 20 us, twice the run
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		reset_n = 1'b0;
		ref_60mhz = 1'b0;
		rd_axis = 1'b0;
		mute = 2'b00;
		extra = 2'b00;
		pwm_mode = 2'b00;
		width[0] = 8'h10;
		width[1] = 8'h10;
		seed = 32'h0000714c;
		n_mismatch = 0;
		tests_run = 0;
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		for (int k = 0; k < 8; k++) begin
			seed = xs(seed);
			width[0] = {2'b00, seed[5:0]} + 8'h08;
			width[1] = {2'b00, seed[13:8]} + 8'h08;
			pwm_mode = k[1:0];
			rd_axis = seed[16];
			q0.push_back({16'h0000, width[0]});
			q1.push_back({16'h0000, width[1]});
			wait (q0.size() == 0 && q1.size() == 0);
			@(negedge clk);
			chk_count(rd_count_r, {16'h0000, width[rd_axis]});
		end
		// Silence axis 1, stray pulse on axis 0 after its reply
		mute = 2'b10;
		extra = 2'b01;
		q0.push_back({16'h0000, width[0]});
		repeat (2) @(negedge interrogate_r[1]);
		@(negedge clk);
		chk_flag({result_r[1].no_transducer, result_r[0].no_transducer,
			result_r[1].noise, result_r[0].noise}, 4'h9);
		report_and_stop();
	end
endmodule // magnetostrictive_position_readout_tb
`default_nettype wire

// >>> position_readout_pkg.sv
// Package for the two-axis transducer position readout.
// Assumes a 100 MHz module clock and a sampled 60 MHz reference level.
package position_readout_pkg;

	localparam int CLK_MHZ = 100;
	localparam int AXES = 2;
	localparam int COUNT_W = 24;
	// Refresh period, printed in microseconds
	localparam int REFRESH_US = 1000;
	localparam int REFRESH_CYCLES = REFRESH_US * CLK_MHZ;
	// Interrogation pulse width in nanoseconds
	localparam int INTERROGATE_NS = 1000;
	localparam int INTERROGATE_CYCLES = (INTERROGATE_NS * CLK_MHZ + 999) / 1000;
	// Longest wait for a return, in microseconds
	localparam int TIMEOUT_US = 900;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_PULSE = 5'b00010,
		ST_WAIT = 5'b00100,
		ST_COUNT = 5'b01000,
		ST_DONE = 5'b10000
	} axis_state_type;

	typedef enum logic {
		MODE_START_STOP = 1'b0,
		MODE_PWM = 1'b1
	} return_mode_type;

	typedef struct packed {
		logic [COUNT_W-1:0] count;
		logic valid;
		logic no_transducer;
		logic noise;
		logic overflow;
	} axis_result_type;

endpackage

// >>> readout_monitor.sv
// Checker for the readout ports.
// Assumes binding into the readout top.
`timescale 1ns/100ps
`default_nettype none
module readout_monitor
	import position_readout_pkg::*;
#(
	parameter int REFRESH = position_readout_pkg::REFRESH_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Watched ports
	input wire logic [1:0] interrogate_r,
	input wire logic [1:0] sample_done_r,
	input wire position_readout_pkg::axis_result_type [1:0] result_r,
	input wire logic rd_axis,
	input wire logic [23:0] rd_count_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [31:0] gap_r, gap_nxt;
	logic seen_r, seen_nxt, prev_r, prev_nxt;
	// Cycles since the last pulse start
	always_comb begin
		gap_nxt = (interrogate_r[0] && !prev_r) ? 32'h00000000 :
			gap_r + 32'h00000001;
		seen_nxt = seen_r | (interrogate_r[0] & ~prev_r);
		prev_nxt = interrogate_r[0];
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_r <= 32'h00000000;
			seen_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			gap_r <= gap_nxt;
			seen_r <= seen_nxt;
			prev_r <= prev_nxt;
		end
	end
	property p_width;
		$rose(interrogate_r[0]) |-> ##99 interrogate_r[0] ##1 !interrogate_r[0];
	endproperty
	a_width: assert property (p_width) else $error("pulse width");
	property p_period;
		$rose(interrogate_r[0]) && seen_r |-> gap_r == REFRESH - 1;
	endproperty
	a_period: assert property (p_period) else $error("period");
	property p_both;
		$rose(interrogate_r[0]) |-> $rose(interrogate_r[1]);
	endproperty
	a_both: assert property (p_both) else $error("axis tick");
	property p_done_one;
		sample_done_r[0] |=> !sample_done_r[0];
	endproperty
	a_done_one: assert property (p_done_one) else $error("done");
	property p_valid;
		sample_done_r[1] |-> result_r[1].valid;
	endproperty
	a_valid: assert property (p_valid) else $error("valid");
	property p_quiet;
		interrogate_r[0] |-> !sample_done_r[0];
	endproperty
	a_quiet: assert property (p_quiet) else $error("done in pulse");
	property p_hold0;
		$changed(result_r[0].count) |-> sample_done_r[0];
	endproperty
	a_hold0: assert property (p_hold0) else $error("count 0 moved");
	property p_hold1;
		$changed(result_r[1].count) |-> sample_done_r[1];
	endproperty
	a_hold1: assert property (p_hold1) else $error("count 1 moved");
	property p_rd;
		(!(|sample_done_r) && $stable(rd_axis)) [*3]
			|-> rd_count_r == result_r[rd_axis].count;
	endproperty
	a_rd: assert property (p_rd) else $error("readback");
endmodule // readout_monitor
bind magnetostrictive_position_readout readout_monitor #(.REFRESH(REFRESH)) mon (
	.clk(clk), .reset_n(reset_n), .interrogate_r(interrogate_r),
	.sample_done_r(sample_done_r), .result_r(result_r),
	.rd_axis(rd_axis), .rd_count_r(rd_count_r));
`default_nettype wire

// >>> transducer_model.sv
// Behavioural transducer for one axis.
// Assumes mode, width, mute and extra change only between pulses.
// Extra is not combined with mute: a stray pulse then looks like a reply.
`timescale 1ns/100ps
`default_nettype none
module transducer_model (
	// Pins
	input wire logic clk,
	input wire logic interrogate,
	output logic ret,
	// Behaviour
	input wire logic pwm,
	input wire logic mute,
	input wire logic [7:0] width,
	input wire logic extra
);
	initial begin
		ret = 1'b0;
		forever begin
			// Skip the unknown-to-low step at reset
			@(posedge interrogate);
			@(negedge interrogate);
			// Answer delay varies with width
			repeat ({4'h0, width[3:0]} + 8'h01) @(negedge clk);
			if (!mute && pwm) begin
				ret = 1'b1;
				repeat (width) @(negedge clk);
				ret = 1'b0;
			end else if (!mute) begin
				ret = 1'b1;
				@(negedge clk) ret = 1'b0;
				repeat (width - 8'h01) @(negedge clk);
				ret = 1'b1;
				@(negedge clk) ret = 1'b0;
			end
			// Stray pulse well after the reply, axis idle by then
			if (extra) begin
				repeat (200) @(negedge clk);
				ret = 1'b1;
				@(negedge clk) ret = 1'b0;
			end
		end
	end
endmodule // transducer_model
`default_nettype wire
